/* File: pkg/lrc_consts.vh */
// Constants for the logic register cell tile
`ifndef LRC_CONSTS_VH
`define LRC_CONSTS_VH

// ****************************************
// Combinational module shape
// ****************************************
`define LRC_LUT_INPUTS 5
`define LRC_LUT_BITS 32
`define LRC_INV_INPUT_POS 0

// ****************************************
// Supergroup kinds
// ****************************************
`define LRC_SUPER_KIND_ONE 1
`define LRC_SUPER_KIND_TWO 2

// ****************************************
// Register reset, clear and preset values
// ****************************************
`define LRC_REG_RESET_VAL 1'h0
`define LRC_REG_CLEAR_VAL 1'h0
`define LRC_REG_PRESET_VAL 1'h1

// ****************************************
// Clock edge and source encodings
// ****************************************
`define LRC_EDGE_RISE 1'h0
`define LRC_EDGE_FALL 1'h1
`define LRC_SRC_HARDWIRED 1'h0
`define LRC_SRC_ROUTED 1'h1

`endif

/* File: logic/lrc_module_supergroup.v */
// One module supergroup: combinational modules and register modules in two clusters
//
// Behaviour
// [R1] Clear forces register low at once
// [R2] Preset forces register high at once
// [R3] Two select lines form the load enable
// [R4] Capture edge chosen per register
// [R5] Clock from hardwired or routed net
// [R6] Five-input configurable function, no storage
// [R7] Invertible data input, true or complement
// [R8] Inversion lets one module make XOR3
// [R9] Clusters: two comb+one reg, or reverse
// [R10] Supergroups: two type-one, or mixed pair
// [R11] Clear wins over preset
// [R12] Register holds value while not enabled

`include "lrc_consts.vh"

module lrc_module_supergroup #(
    parameter SUPER_KIND = `LRC_SUPER_KIND_ONE
) (
    // Clock and reset
    input wire sys_clk,
    input wire reset,
    // Clock networks, asynchronous to sys_clk
    input wire hardwiredClk,
    input wire routedClk,
    // Combinational module configuration and inputs
    input wire [(((SUPER_KIND == `LRC_SUPER_KIND_ONE) ? 4 : 3) * `LRC_LUT_BITS) - 1:0] combFunction,
    input wire [((SUPER_KIND == `LRC_SUPER_KIND_ONE) ? 4 : 3) - 1:0] combInvert,
    input wire [(((SUPER_KIND == `LRC_SUPER_KIND_ONE) ? 4 : 3) * `LRC_LUT_INPUTS) - 1:0] combIn,
    // Register module configuration
    input wire [((SUPER_KIND == `LRC_SUPER_KIND_ONE) ? 2 : 3) - 1:0] regFallEdge,
    input wire [((SUPER_KIND == `LRC_SUPER_KIND_ONE) ? 2 : 3) - 1:0] regRoutedSrc,
    input wire [((SUPER_KIND == `LRC_SUPER_KIND_ONE) ? 2 : 3) - 1:0] regUseComb,
    // Register module controls and data
    input wire [((SUPER_KIND == `LRC_SUPER_KIND_ONE) ? 2 : 3) - 1:0] regData,
    input wire [((SUPER_KIND == `LRC_SUPER_KIND_ONE) ? 2 : 3) - 1:0] enable_select_line_zero,
    input wire [((SUPER_KIND == `LRC_SUPER_KIND_ONE) ? 2 : 3) - 1:0] enable_select_line_one,
    input wire [((SUPER_KIND == `LRC_SUPER_KIND_ONE) ? 2 : 3) - 1:0] regClear,
    input wire [((SUPER_KIND == `LRC_SUPER_KIND_ONE) ? 2 : 3) - 1:0] regPreset,
    // Results
    output wire [((SUPER_KIND == `LRC_SUPER_KIND_ONE) ? 4 : 3) - 1:0] combOut,
    output wire [((SUPER_KIND == `LRC_SUPER_KIND_ONE) ? 2 : 3) - 1:0] regOut
);

    // ****************************************
    // Cell counts per supergroup kind
    // ****************************************
    // Kind one: two type-one clusters, four comb and two reg modules [R10] [R9]
    // Kind two: one type-one and one type-two cluster, three and three [R10] [R9]
    localparam NUM_COMB = (SUPER_KIND == `LRC_SUPER_KIND_ONE) ? 4 : 3;
    localparam NUM_REG = (SUPER_KIND == `LRC_SUPER_KIND_ONE) ? 2 : 3;

    // Comb module that shares a cluster with a given register [R9]
    function integer clusterComb;
        input integer regIdx;
        begin
            if (SUPER_KIND == `LRC_SUPER_KIND_ONE) begin
                clusterComb = regIdx * 2;
            end else begin
                clusterComb = (regIdx == 0) ? 0 : 2;
            end
        end
    endfunction

    // Table lookup with the invertible data input in the low address bit
    function lutEval;
        input [`LRC_LUT_BITS-1:0] lutTable;
        input [`LRC_LUT_INPUTS-1:0] ins;
        input inv;
        reg [`LRC_LUT_INPUTS-1:0] addr;
        begin
            addr = ins;
            addr[`LRC_INV_INPUT_POS] = ins[`LRC_INV_INPUT_POS] ^ inv; // [R7]
            lutEval = lutTable[addr]; // [R6]
        end
    endfunction

    // ****************************************
    // Combinational modules
    // ****************************************
    // Purely combinational so chained logic sees no added latency;
    // an XOR3 is the table 8'h96 on three inputs, or its complement
    // with the invertible input flipped [R8]
    genvar c;
    generate
        for (c = 0; c < NUM_COMB; c = c + 1) begin : gComb
            wire [`LRC_LUT_INPUTS-1:0] invertible_data_input;
            assign invertible_data_input = combIn[c*`LRC_LUT_INPUTS +: `LRC_LUT_INPUTS];
            assign combOut[c] = lutEval(combFunction[c*`LRC_LUT_BITS +: `LRC_LUT_BITS],
                invertible_data_input, combInvert[c]); // [R6] [R8]
        end
    endgenerate

    // ****************************************
    // Clock network sampling
    // ****************************************
    // Both networks are foreign to sys_clk, so each passes two flops;
    // a third stage only serves edge detection
    reg hwMeta_q;
    reg hwSync_q;
    reg hwPrev_q;
    reg rtMeta_q;
    reg rtSync_q;
    reg rtPrev_q;

    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            hwMeta_q <= 1'h0;
            hwSync_q <= 1'h0;
            hwPrev_q <= 1'h0;
            rtMeta_q <= 1'h0;
            rtSync_q <= 1'h0;
            rtPrev_q <= 1'h0;
        end else begin
            hwMeta_q <= hardwiredClk;
            hwSync_q <= hwMeta_q;
            hwPrev_q <= hwSync_q;
            rtMeta_q <= routedClk;
            rtSync_q <= rtMeta_q;
            rtPrev_q <= rtSync_q;
        end
    end

    wire hwRise = hwSync_q & ~hwPrev_q;
    wire hwFall = ~hwSync_q & hwPrev_q;
    wire rtRise = rtSync_q & ~rtPrev_q;
    wire rtFall = ~rtSync_q & rtPrev_q;

    // ****************************************
    // Register modules
    // ****************************************
    // Limitation: a network edge is seen two to three sys_clk cycles late,
    // so network clocks must be slower than a quarter of sys_clk
    genvar r;
    generate
        for (r = 0; r < NUM_REG; r = r + 1) begin : gReg
            wire srcRise;
            wire srcFall;
            wire activeEdge;
            wire loadEn;
            wire dataIn;
            wire clearAny;
            reg cell_q;
            reg cell_d;

            assign srcRise = (regRoutedSrc[r] == `LRC_SRC_ROUTED) ? rtRise : hwRise; // [R5]
            assign srcFall = (regRoutedSrc[r] == `LRC_SRC_ROUTED) ? rtFall : hwFall; // [R5]
            assign activeEdge = (regFallEdge[r] == `LRC_EDGE_FALL) ? srcFall : srcRise; // [R4]
            assign loadEn = enable_select_line_zero[r] | enable_select_line_one[r]; // [R3]
            assign dataIn = regUseComb[r] ? combOut[clusterComb(r)] : regData[r]; // [R9]
            assign clearAny = reset | regClear[r];

            always @* begin
                cell_d = cell_q; // [R12]
                if (activeEdge && loadEn) begin
                    cell_d = dataIn; // [R3]
                end
            end

            // Clear is tested first so it dominates preset [R11]
            always @(posedge sys_clk or posedge clearAny or posedge regPreset[r]) begin
                if (clearAny) begin
                    cell_q <= `LRC_REG_CLEAR_VAL; // [R1] [R11]
                end else if (regPreset[r]) begin
                    cell_q <= `LRC_REG_PRESET_VAL; // [R2]
                end else begin
                    cell_q <= cell_d;
                end
            end

            assign regOut[r] = cell_q;
        end
    endgenerate

endmodule

/* File: tb/lrc_clock_net.sv */
// Far-side clock nets: one pulse per request, low between pulses
module lrc_clock_net (
    // Request
    input logic sys_clk,
    input logic [1:0] pulseReq,
    // Nets
    output logic hardwiredClk,
    output logic routedClk
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] cnt_q = 3'h0;
    logic [1:0] sel_q = 2'h0;
    // Six cycles high so each phase spans at least two sampling edges
    always @(posedge sys_clk) cnt_q <= (pulseReq != 2'h0) ? 3'h6 : cnt_q - {2'h0, cnt_q != 3'h0};
    always @(posedge sys_clk) sel_q <= (pulseReq != 2'h0) ? pulseReq : sel_q;
    assign {routedClk, hardwiredClk} = (cnt_q != 3'h0) ? sel_q : 2'h0;
endmodule

/* File: tb/lrc_supergroup_properties.sv */
// Assertions on the register modules of one supergroup
module lrc_supergroup_properties #(parameter SUPER_KIND = 1, parameter NR = (SUPER_KIND == 1) ? 2 : 3) (
    // Clock and reset
    input wire sys_clk,
    input wire reset,
    // Register pins
    input wire [NR-1:0] enable_select_line_zero,
    input wire [NR-1:0] enable_select_line_one,
    input wire [NR-1:0] regClear,
    input wire [NR-1:0] regPreset,
    input wire [NR-1:0] regOut
);
    wire [NR-1:0] en = enable_select_line_zero | enable_select_line_one;
    wire [NR-1:0] asyncAct = regClear | regPreset;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    property p_clr; regClear[0] |-> !regOut[0]; endproperty
    a_clr: assert property (p_clr) else $error("clear");
    property p_clrOff; $fell(regClear[0]) && !regPreset[0] |-> !regOut[0]; endproperty
    a_clrOff: assert property (p_clrOff) else $error("clear release");
    property p_pre; regPreset[1] && !regClear[1] |-> regOut[1]; endproperty
    a_pre: assert property (p_pre) else $error("preset");
    property p_preOff; $fell(regPreset[1]) && !regClear[1] |-> regOut[1]; endproperty
    a_preOff: assert property (p_preOff) else $error("preset release");
    property p_prio; regClear[0] && regPreset[0] |-> !regOut[0] ##1 (!regClear[0] || !regOut[0]); endproperty
    a_prio: assert property (p_prio) else $error("priority");
    property p_hold; !$past(en[0]) && !$past(asyncAct[0]) && !asyncAct[0] |-> $stable(regOut[0]); endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_rise; $rose(regOut[0]) && !$past(asyncAct[0]) && !asyncAct[0] |-> $past(en[0]); endproperty
    a_rise: assert property (p_rise) else $error("load rise");
    property p_fall; $fell(regOut[1]) && !$past(asyncAct[1]) && !asyncAct[1] |-> $past(en[1]); endproperty
    a_fall: assert property (p_fall) else $error("load fall");
endmodule
bind lrc_module_supergroup lrc_supergroup_properties #(.SUPER_KIND(SUPER_KIND)) u_lrc_supergroup_properties (
    .sys_clk, .reset, .enable_select_line_zero, .enable_select_line_one, .regClear, .regPreset, .regOut);

/* File: tb/logic_register_cell_bench.sv */
// Bench for two module supergroups, one of each kind, driven by their clock-net partner
module logic_register_cell_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0, reset = 1'b1, hwClk, rtClk;
    logic [1:0] req = 2'h0, fall = 2'h0, src = 2'h0, useC = 2'h0, dat = 2'h0, s0 = 2'h0;
    logic [1:0] s1 = 2'h0, clr = 2'h0, pre = 2'h0, q;
    logic [3:0] inv = 4'h0, y;
    logic [19:0] cin = 20'h0;
    logic [2:0] useC2 = 3'h0, en2 = 3'h0, y2, q2;
    logic [14:0] cin2 = 15'h0;
    int fail_count = 0, n_tests = 0;
    initial forever #10 sys_clk = ~sys_clk;
    lrc_module_supergroup u_lrc_module_supergroup (.sys_clk(sys_clk), .reset(reset), .hardwiredClk(hwClk),
        .routedClk(rtClk), .combFunction({4{32'h96969696}}), .combInvert(inv), .combIn(cin), .regFallEdge(fall),
        .regRoutedSrc(src), .regUseComb(useC), .regData(dat), .enable_select_line_zero(s0),
        .enable_select_line_one(s1), .regClear(clr), .regPreset(pre), .combOut(y), .regOut(q));
    lrc_clock_net u_lrc_clock_net (.sys_clk(sys_clk), .pulseReq(req), .hardwiredClk(hwClk), .routedClk(rtClk));
    // Mixed-cluster supergroup: three comb and three register modules
    lrc_module_supergroup #(.SUPER_KIND(2)) u_lrc_module_supergroup_two (.sys_clk(sys_clk), .reset(reset),
        .hardwiredClk(hwClk), .routedClk(rtClk), .combFunction({3{32'h96969696}}), .combInvert(3'h0),
        .combIn(cin2), .regFallEdge(3'h0), .regRoutedSrc(3'h0), .regUseComb(useC2), .regData(3'h0),
        .enable_select_line_zero(en2), .enable_select_line_one(3'h0), .regClear(3'h0), .regPreset(3'h0),
        .combOut(y2), .regOut(q2));
    task automatic chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
        n_tests++;
        fail_count += int'(seen !== exp);
        if (seen !== exp) $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // A network edge needs three sys_clk edges to reach the register
    task automatic pulse(input logic [1:0] net, input logic [3:0] mid, input logic [3:0] fin);
        @(posedge sys_clk) req <= net;
        @(posedge sys_clk) req <= 2'h0;
        repeat (5) @(posedge sys_clk);
        #1 chk("regOut rise", {2'h0, q}, mid);
        repeat (6) @(posedge sys_clk);
        #1 chk("regOut fall", {2'h0, q}, fin);
    endtask
    task automatic t_comb;
        for (int i = 0; i < 16; i++) begin
            @(posedge sys_clk) inv <= {4{i[3]}};
            cin <= {4{2'h0, i[2:0]}};
            #1 chk("combOut", y, {4{^i[2:0] ^ i[3]}});
        end
    endtask
    task automatic t_load;
        {inv, cin, dat} <= {4'h0, 20'h1, 2'h3};
        pulse(2'h1, 4'h0, 4'h0);
        {s0, s1} <= {2'h1, 2'h2};
        pulse(2'h1, 4'h3, 4'h3);
        {dat, useC} <= {2'h0, 2'h1};
        pulse(2'h1, 4'h1, 4'h1);
    endtask
    task automatic t_edge;
        {fall, src, useC, dat} <= {2'h2, 2'h2, 2'h0, 2'h2};
        pulse(2'h1, 4'h0, 4'h0);
        pulse(2'h2, 4'h0, 4'h2);
    endtask
    task automatic t_async;
        pre <= 2'h3;
        #1 chk("preset", {2'h0, q}, 4'h3);
        {clr, dat} <= {2'h1, 2'h1};
        #1 chk("clear", {2'h0, q}, 4'h2);
        pulse(2'h3, 4'h2, 4'h2);
        {clr, pre} <= 4'h0;
        #1 chk("release", {2'h0, q}, 4'h2);
    endtask
    // Register 0 pairs with comb 0, registers 1 and 2 share comb 2
    task automatic t_kind_two;
        @(posedge sys_clk) {cin2, useC2, en2} <= {15'h1, 3'h7, 3'h7};
        @(posedge sys_clk) req <= 2'h1;
        @(posedge sys_clk) req <= 2'h0;
        repeat (5) @(posedge sys_clk);
        #1 chk("combOut kind two", {1'h0, y2}, 4'h1);
        chk("regOut kind two", {1'h0, q2}, 4'h1);
        repeat (6) @(posedge sys_clk);
    endtask
    initial begin
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        t_comb;
        t_load;
        t_edge;
        t_async;
        t_kind_two;
        repeat (3) @(posedge sys_clk);
        give_verdict;
    end
endmodule
